//--- common/charger_regs_pkg.sv
// Register map, field layout and types of the charger register bank
package charger_regs_pkg;

  // ----------------------------------------------------------------
  // Bus address and register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR                 = 7'h6a;
  localparam logic [7:0] REG_INPUT_CURRENT_LIMIT  = 8'h00;
  localparam logic [7:0] REG_CHARGER_CONTROL_ZERO = 8'h01;
  localparam logic [7:0] REG_CHARGE_CURRENT_LIMIT = 8'h02;
  localparam logic [7:0] REG_PRECHARGE_TERM_LIMIT = 8'h03;
  localparam logic [7:0] REG_BATTERY_VOLT_LIMIT   = 8'h04;
  localparam logic [7:0] REG_CHARGER_CONTROL_ONE  = 8'h05;
  localparam logic [7:0] REG_CHARGER_CONTROL_TWO  = 8'h06;
  localparam logic [7:0] REG_CHARGER_CONTROL_THR  = 8'h07;
  localparam logic [7:0] REG_CHARGER_STATUS_ZERO  = 8'h08;
  localparam logic [7:0] REG_CHARGER_STATUS_ONE   = 8'h09;
  localparam logic [7:0] REG_CHARGER_STATUS_TWO   = 8'h0a;
  localparam logic [7:0] REG_PART_INFORMATION     = 8'h0b;
  localparam logic [7:0] REG_CHARGER_CONTROL_FOUR = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_HIGH_IMPEDANCE       = 7;
  localparam int         BIT_THERMISTOR_BYPASS    = 6;
  localparam int         BIT_REMOTE_SENSE_DISABLE = 5;
  localparam int         NTC_CODE_MSB             = 2;
  localparam logic [7:0] RST_INPUT_CURRENT_LIMIT  = 8'h17;
  localparam logic [7:0] RST_CHARGER_CONTROL_ZERO = 8'h1a;
  localparam logic [7:0] RST_CHARGE_CURRENT_LIMIT = 8'h91;
  localparam logic [7:0] RST_OTHER_CONTROL        = 8'h00;
  // Arbitrary value, not a real part code
  localparam logic [7:0] PART_INFO_VALUE          = 8'h00;
  localparam logic [7:0] UNMAPPED_READ            = 8'hff;
  localparam logic [2:0] NTC_NORMAL               = 3'h0;
  localparam logic [3:0] BYTE_BITS                = 4'h8;

  // ----------------------------------------------------------------
  // Input current limit encoding
  // ----------------------------------------------------------------
  localparam int LIMIT_OFFSET_MA = 100;
  localparam int LIMIT_STEP_MA   = 100;
  localparam int AUTO_HIGH_MA    = 500;
  localparam int AUTO_LOW_MA     = 2400;

  function automatic logic [4:0] ma_to_code(input int ma);
    return 5'((ma - LIMIT_OFFSET_MA) / LIMIT_STEP_MA);
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] control_zero;
    logic [7:0] charge_current;
    logic [7:0] precharge_term;
    logic [7:0] battery_volt;
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] control_three;
    logic [7:0] control_four;
  } ctrl_bank_t;

  typedef struct packed {
    logic [7:0] status_zero;
    logic [7:0] status_one;
    logic [7:0] status_two;
  } status_in_t;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WR_BYTE  = 7'b0001000,
    ST_WR_ACK   = 7'b0010000,
    ST_RD_BYTE  = 7'b0100000,
    ST_RD_ACK   = 7'b1000000
  } bus_state_t;

endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int                 WIDTH       = 1,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] level_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff  <= RESET_VALUE;
      level_ff <= RESET_VALUE;
    end else begin
      meta_ff  <= pin_in;
      level_ff <= meta_ff;
    end
  end

  assign level_out = level_ff;

endmodule // pin_sync
`default_nettype wire

//--- rtl/current_limit_reg.sv
// Input current limit register with automatic source-detect update
`timescale 1ns/10ps
`default_nettype none
module current_limit_reg
  import charger_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       register_reset,
  input  wire logic       watchdog_expired,
  input  wire logic       detect_done,
  input  wire logic       source_select,
  output logic      [7:0] value
);

  localparam logic [4:0] CODE_HIGH = ma_to_code(AUTO_HIGH_MA);
  localparam logic [4:0] CODE_LOW  = ma_to_code(AUTO_LOW_MA);

  logic [7:0] value_ff;
  logic       seen_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_ff <= RST_INPUT_CURRENT_LIMIT;
    end else if (register_reset) begin
      value_ff <= RST_INPUT_CURRENT_LIMIT;
    end else begin
      if (wr_en) begin
        value_ff <= wr_data;
      end
      if (watchdog_expired) begin
        value_ff[BIT_HIGH_IMPEDANCE] <= 1'b0;
      end
      if (detect_done) begin
        value_ff[4:0] <= source_select ? CODE_HIGH : CODE_LOW;
      end
    end
  end

  // Marks the first cycle after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end

  assign value = value_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  por_default_a: assert property (!seen_ff |-> value_ff == RST_INPUT_CURRENT_LIMIT)
    else $error("limit register not at power-on default");
  reg_reset_a: assert property (register_reset |=> value_ff == RST_INPUT_CURRENT_LIMIT)
    else $error("register reset did not restore limit default");
  auto_limit_a: assert property (detect_done && !register_reset |=>
    value_ff[4:0] == ($past(source_select) ? CODE_HIGH : CODE_LOW))
    else $error("source detect did not set limit code");

endmodule // current_limit_reg
`default_nettype wire

//--- rtl/charger_i2c_register_bank.sv
// Two-wire target and register bank of the single-cell charger
//
// Summary of operation
// - Answer bus address 0x6A plus direction bit
// - Limit register loads 0x17 at power-on
// - Bit7 enables high-impedance input, watchdog clears
// - Bit6 set treats thermistor as always good
// - Bypass reports thermistor fault code as 000
// - Bit5 picks remote sense or cell terminal
// - Remote sense fault falls back to cell terminal
// - Limit code is 100 mA plus 100 mA steps
// - Limit field defaults 10111, restored by reset
// - Source detect sets 500 mA or 2.4 A
// - Reads above offset 0x0C return 0xFF
// - Burst access auto-increments register pointer
`timescale 1ns/10ps
`default_nettype none
module charger_i2c_register_bank
  import charger_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       thermistor_pin_good,
  input  wire logic       remote_sense_fault_flag,
  input  wire logic       source_select_pin,
  input  wire logic       source_detect_done_pin,
  input  wire logic [2:0] thermistor_fault_code,
  input  wire status_in_t status_in,
  input  wire logic       register_reset,
  input  wire logic       watchdog_expired,
  output logic            high_impedance_input_enable,
  output logic            thermistor_condition_good,
  output logic            cv_from_cell_terminal,
  output logic      [4:0] input_current_limit_field,
  output ctrl_bank_t      ctrl_bank
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       scl_s;
  logic       sda_s;
  logic       therm_good_s;
  logic       sense_fault_s;
  logic       source_sel_s;
  logic       detect_s;

  pin_sync #(.WIDTH(2), .RESET_VALUE(2'b11)) u_bus_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .pin_in    ({scl_in, sda_in}),
    .level_out ({scl_s, sda_s})
  );

  pin_sync #(.WIDTH(4), .RESET_VALUE(4'h0)) u_pin_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .pin_in    ({thermistor_pin_good, remote_sense_fault_flag, source_select_pin, source_detect_done_pin}),
    .level_out ({therm_good_s, sense_fault_s, source_sel_s, detect_s})
  );

  // ----------------------------------------------------------------
  // Bus edge and condition detection
  // ----------------------------------------------------------------
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic       detect_q_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_ff    <= 1'b1;
      sda_q_ff    <= 1'b1;
      detect_q_ff <= 1'b0;
    end else begin
      scl_q_ff    <= scl_s;
      sda_q_ff    <= sda_s;
      detect_q_ff <= detect_s;
    end
  end

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       detect_done;

  assign scl_rise    = scl_s & ~scl_q_ff;
  assign scl_fall    = ~scl_s & scl_q_ff;
  assign start_cond  = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_cond   = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign detect_done = detect_s & ~detect_q_ff;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  bus_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic       rw_ff;
  logic       nack_ff;
  logic       ptr_pending_ff;
  logic       byte_done;
  logic       addr_hit;
  logic       wr_stb;
  logic       load_tx;
  logic [7:0] rd_data;

  assign byte_done = bit_cnt_ff == BYTE_BITS;
  assign addr_hit  = rx_ff[7:1] == DEV_ADDR;
  assign wr_stb    = scl_fall && state_ff == ST_WR_BYTE && byte_done && !ptr_pending_ff;
  assign load_tx   = scl_fall && ((state_ff == ST_ADDR_ACK && rw_ff) || (state_ff == ST_RD_ACK && !nack_ff));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else if (stop_cond) begin
      state_ff <= ST_IDLE;
    end else if (start_cond) begin
      state_ff <= ST_ADDR;
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR: begin
          if (byte_done) begin
            state_ff <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: state_ff <= rw_ff ? ST_RD_BYTE : ST_WR_BYTE;
        ST_WR_BYTE: begin
          if (byte_done) begin
            state_ff <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: state_ff <= ST_WR_BYTE;
        ST_RD_BYTE: begin
          if (byte_done) begin
            state_ff <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: state_ff <= nack_ff ? ST_IDLE : ST_RD_BYTE;
        default: state_ff <= state_ff;
      endcase
    end
  end

  // Bit counter counts rising clock edges inside a byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= '0;
    end else if (start_cond) begin
      bit_cnt_ff <= '0;
    end else if (scl_fall && (state_ff == ST_ADDR_ACK || state_ff == ST_WR_ACK || state_ff == ST_RD_ACK)) begin
      bit_cnt_ff <= '0;
    end else if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_WR_BYTE || state_ff == ST_RD_BYTE)) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ff   <= '0;
      nack_ff <= 1'b0;
    end else if (scl_rise) begin
      if (state_ff == ST_ADDR || state_ff == ST_WR_BYTE) begin
        rx_ff <= {rx_ff[6:0], sda_s};
      end
      if (state_ff == ST_RD_ACK) begin
        nack_ff <= sda_s;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rw_ff <= 1'b0;
    end else if (scl_fall && state_ff == ST_ADDR && byte_done) begin
      rw_ff <= rx_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff         <= '0;
      ptr_pending_ff <= 1'b0;
    end else if (scl_fall) begin
      if (state_ff == ST_ADDR_ACK) begin
        ptr_pending_ff <= ~rw_ff;
      end else if (state_ff == ST_WR_BYTE && byte_done && ptr_pending_ff) begin
        ptr_ff         <= rx_ff;
        ptr_pending_ff <= 1'b0;
      end else if ((state_ff == ST_WR_BYTE || state_ff == ST_RD_BYTE) && byte_done) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] limit_reg;
  ctrl_bank_t ctrl_ff;

  current_limit_reg u_limit (
    .clk              (clk),
    .arst_n           (arst_n),
    .wr_en            (wr_stb && ptr_ff == REG_INPUT_CURRENT_LIMIT),
    .wr_data          (rx_ff),
    .register_reset   (register_reset),
    .watchdog_expired (watchdog_expired),
    .detect_done      (detect_done),
    .source_select    (source_sel_s),
    .value            (limit_reg)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= '{RST_CHARGER_CONTROL_ZERO, RST_CHARGE_CURRENT_LIMIT, RST_OTHER_CONTROL, RST_OTHER_CONTROL,
                   RST_OTHER_CONTROL, RST_OTHER_CONTROL, RST_OTHER_CONTROL, RST_OTHER_CONTROL};
    end else if (register_reset) begin
      ctrl_ff <= '{RST_CHARGER_CONTROL_ZERO, RST_CHARGE_CURRENT_LIMIT, RST_OTHER_CONTROL, RST_OTHER_CONTROL,
                   RST_OTHER_CONTROL, RST_OTHER_CONTROL, RST_OTHER_CONTROL, RST_OTHER_CONTROL};
    end else if (wr_stb) begin
      // Status and part information offsets fall to default
      case (ptr_ff)
        REG_CHARGER_CONTROL_ZERO: ctrl_ff.control_zero   <= rx_ff;
        REG_CHARGE_CURRENT_LIMIT: ctrl_ff.charge_current <= rx_ff;
        REG_PRECHARGE_TERM_LIMIT: ctrl_ff.precharge_term <= rx_ff;
        REG_BATTERY_VOLT_LIMIT:   ctrl_ff.battery_volt   <= rx_ff;
        REG_CHARGER_CONTROL_ONE:  ctrl_ff.control_one    <= rx_ff;
        REG_CHARGER_CONTROL_TWO:  ctrl_ff.control_two    <= rx_ff;
        REG_CHARGER_CONTROL_THR:  ctrl_ff.control_three  <= rx_ff;
        REG_CHARGER_CONTROL_FOUR: ctrl_ff.control_four   <= rx_ff;
        default:                  ctrl_ff                <= ctrl_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data and transmit shifter
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr_ff)
      REG_INPUT_CURRENT_LIMIT:  rd_data = limit_reg;
      REG_CHARGER_CONTROL_ZERO: rd_data = ctrl_ff.control_zero;
      REG_CHARGE_CURRENT_LIMIT: rd_data = ctrl_ff.charge_current;
      REG_PRECHARGE_TERM_LIMIT: rd_data = ctrl_ff.precharge_term;
      REG_BATTERY_VOLT_LIMIT:   rd_data = ctrl_ff.battery_volt;
      REG_CHARGER_CONTROL_ONE:  rd_data = ctrl_ff.control_one;
      REG_CHARGER_CONTROL_TWO:  rd_data = ctrl_ff.control_two;
      REG_CHARGER_CONTROL_THR:  rd_data = ctrl_ff.control_three;
      REG_CHARGER_STATUS_ZERO:  rd_data = status_in.status_zero;
      REG_CHARGER_STATUS_ONE: begin
        rd_data = {status_in.status_one[7:NTC_CODE_MSB+1], thermistor_fault_code};
        if (limit_reg[BIT_THERMISTOR_BYPASS]) begin
          rd_data[NTC_CODE_MSB:0] = NTC_NORMAL;
        end
      end
      REG_CHARGER_STATUS_TWO:   rd_data = status_in.status_two;
      REG_PART_INFORMATION:     rd_data = PART_INFO_VALUE;
      REG_CHARGER_CONTROL_FOUR: rd_data = ctrl_ff.control_four;
      default:                  rd_data = UNMAPPED_READ;
    endcase
  end

  // Open-drain data: enable pulls the line low
  logic       sda_oe_ff;
  logic       sda_out_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ff      <= '0;
      sda_oe_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe_ff <= 1'b0;
    end else if (load_tx) begin
      tx_ff     <= rd_data;
      sda_oe_ff <= ~rd_data[7];
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR:    sda_oe_ff <= byte_done && addr_hit;
        ST_WR_BYTE: sda_oe_ff <= byte_done;
        ST_RD_BYTE: begin
          if (byte_done) begin
            sda_oe_ff <= 1'b0;
          end else begin
            tx_ff     <= {tx_ff[6:0], 1'b0};
            sda_oe_ff <= ~tx_ff[6];
          end
        end
        default:    sda_oe_ff <= 1'b0;
      endcase
    end
  end

  assign sda_oe  = sda_oe_ff;
  assign sda_out = sda_out_ff;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic       hiz_ff;
  logic       therm_ok_ff;
  logic       cv_cell_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hiz_ff      <= 1'b0;
      therm_ok_ff <= 1'b0;
      cv_cell_ff  <= 1'b0;
    end else begin
      hiz_ff      <= limit_reg[BIT_HIGH_IMPEDANCE];
      therm_ok_ff <= limit_reg[BIT_THERMISTOR_BYPASS] | therm_good_s;
      cv_cell_ff  <= limit_reg[BIT_REMOTE_SENSE_DISABLE] | sense_fault_s;
    end
  end

  assign high_impedance_input_enable = hiz_ff;
  assign thermistor_condition_good   = therm_ok_ff;
  assign cv_from_cell_terminal       = cv_cell_ff;
  assign input_current_limit_field   = limit_reg[4:0];
  assign ctrl_bank                   = ctrl_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_end;
    scl_fall && state_ff == ST_ADDR && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence s_ack_driven;
    state_ff == ST_ADDR_ACK && sda_oe_ff;
  endsequence

  addr_match_a: assert property (s_addr_end ##0 addr_hit |=> s_ack_driven)
    else $error("own address not acknowledged");
  addr_other_a: assert property (s_addr_end ##0 !addr_hit |=> state_ff == ST_IDLE && !sda_oe_ff)
    else $error("foreign address answered");
  hiz_clear_a: assert property (watchdog_expired |=> ##1 !high_impedance_input_enable)
    else $error("watchdog left high impedance enabled");
  therm_bypass_a: assert property (limit_reg[BIT_THERMISTOR_BYPASS] |=> thermistor_condition_good)
    else $error("bypass did not force thermistor good");
  ntc_report_a: assert property (load_tx && ptr_ff == REG_CHARGER_STATUS_ONE && limit_reg[BIT_THERMISTOR_BYPASS]
    |=> tx_ff[NTC_CODE_MSB:0] == NTC_NORMAL)
    else $error("fault code not normal under bypass");
  remote_sense_a: assert property (!limit_reg[BIT_REMOTE_SENSE_DISABLE] && !sense_fault_s
    |=> !cv_from_cell_terminal)
    else $error("cell terminal used with remote sense healthy");
  sense_fallback_a: assert property (sense_fault_s |=> cv_from_cell_terminal)
    else $error("sense fault did not fall back to cell terminal");
  unmapped_read_a: assert property (load_tx && ptr_ff > REG_CHARGER_CONTROL_FOUR
    |=> tx_ff == UNMAPPED_READ)
    else $error("unmapped read not all ones");
  burst_incr_a: assert property (wr_stb && !start_cond && !stop_cond |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer did not advance after data byte");
  ro_write_a: assert property (wr_stb && !register_reset && ptr_ff >= REG_CHARGER_STATUS_ZERO
    && ptr_ff <= REG_PART_INFORMATION |=> $stable(ctrl_ff))
    else $error("read-only write changed control bank");

endmodule // charger_i2c_register_bank
`default_nettype wire

//--- verif/i2c_host_model.sv
// Two-wire bus controller model that drives the register bank
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
  import charger_regs_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  logic [7:0] rdat [4];
  logic       acked;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // ------------------------------------------------------------
  // Bus phases, data bits move while the clock is low, start and stop while it is high
  // ------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic start();
    wait_n(4);
    sda_pull = 1'b0;
    wait_n(8);
    scl = 1'b1;
    wait_n(8);
    sda_pull = 1'b1;
    wait_n(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    wait_n(4);
    sda_pull = 1'b1;
    wait_n(8);
    scl = 1'b1;
    wait_n(8);
    sda_pull = 1'b0;
    wait_n(8);
  endtask

  task automatic xbit(input logic b, output logic s);
    wait_n(4);
    sda_pull = ~b;
    wait_n(8);
    scl = 1'b1;
    wait_n(8);
    s = sda_line;
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], s);
    end
    xbit(1'b1, s);
    if (s) begin
      acked = 1'b0;
    end
  endtask

  task automatic write(input logic [6:0] a, input logic [7:0] p, d0, d1, input int n);
    acked = 1'b1;
    start();
    wbyte({a, 1'b0});
    wbyte(p);
    wbyte(d0);
    if (n > 1) begin
      wbyte(d1);
    end
    stop();
  endtask

  task automatic read(input logic [7:0] p, input int n);
    logic s;
    acked = 1'b1;
    start();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(p);
    start();
    wbyte({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        xbit(1'b1, rdat[k][i]);
      end
      xbit(k == n - 1, s);
    end
    stop();
  endtask
endmodule // i2c_host_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the charger register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb import charger_regs_pkg::*;;
  logic       clk, arst_n, scl, sda_pull, sda_line, sda_oe, sda_out;
  logic       tg_pin, flt_pin, sel_pin, det_pin, reg_rst, wd_exp;
  logic       hiz, tgood, cv_cell;
  logic [2:0] ntc;
  logic [4:0] limit;
  status_in_t stat;
  ctrl_bank_t bank;
  int         num_errors, compares;

  // Open-drain line with pull-up: low when host pulls or device drives its data value low
  assign sda_line = !sda_pull && !(sda_oe && !sda_out);

  i2c_host_model i2c_host_model_i (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  charger_i2c_register_bank charger_i2c_register_bank_i (.clk(clk), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .thermistor_pin_good(tg_pin),
    .remote_sense_fault_flag(flt_pin), .source_select_pin(sel_pin), .source_detect_done_pin(det_pin),
    .thermistor_fault_code(ntc), .status_in(stat), .register_reset(reg_rst), .watchdog_expired(wd_exp),
    .high_impedance_input_enable(hiz), .thermistor_condition_good(tgood), .cv_from_cell_terminal(cv_cell),
    .input_current_limit_field(limit), .ctrl_bank(bank));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
    settle();
  endtask

  task automatic wr(input logic [7:0] p, d0, d1, input int n);
    i2c_host_model_i.write(DEV_ADDR, p, d0, d1, n);
    settle();
  endtask

  task automatic rchk(input string nm, input logic [7:0] p, e);
    i2c_host_model_i.read(p, 1);
    `CHK(nm, e, i2c_host_model_i.rdat[0])
  endtask

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    {arst_n, tg_pin, flt_pin, sel_pin, det_pin, reg_rst, wd_exp, ntc} = '0;
    stat = 24'h5a3c96;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    settle();
    `CHK("limit", 5'h17, limit)
    `CHK("therm", 1'b0, tgood)
    `CHK("bank", 64'h1a91000000000000, bank)
    i2c_host_model_i.read(8'h00, 3);
    `CHK("r00", 8'h17, i2c_host_model_i.rdat[0])
    `CHK("r01", 8'h1a, i2c_host_model_i.rdat[1])
    `CHK("r02", 8'h91, i2c_host_model_i.rdat[2])
    $display("test reset done");
    wr(8'h00, 8'he5, 8'h3c, 2);
    `CHK("ack", 1'b1, i2c_host_model_i.acked)
    `CHK("hiz", 1'b1, hiz)
    `CHK("therm", 1'b1, tgood)
    `CHK("cv", 1'b1, cv_cell)
    `CHK("limit", 5'h05, limit)
    `CHK("ctl0", 8'h3c, bank.control_zero)
    ntc = 3'h5;
    rchk("ntc", 8'h09, {stat.status_one[7:3], 3'h0});
    $display("test fields done");
    pulse(wd_exp);
    `CHK("hiz", 1'b0, hiz)
    rchk("r00", 8'h00, 8'h65);
    wr(8'h00, 8'h17, 8'h00, 1);
    tg_pin = 1'b1;
    flt_pin = 1'b1;
    settle();
    `CHK("therm", 1'b1, tgood)
    `CHK("cv", 1'b1, cv_cell)
    flt_pin = 1'b0;
    settle();
    `CHK("cv", 1'b0, cv_cell)
    rchk("ntc", 8'h09, {stat.status_one[7:3], 3'h5});
    $display("test watchdog done");
    wr(8'h08, 8'hff, 8'h00, 1);
    rchk("r08", 8'h08, stat.status_zero);
    rchk("r0d", 8'h0d, 8'hff);
    rchk("r0a", 8'h0a, stat.status_two);
    rchk("r0b", 8'h0b, PART_INFO_VALUE);
    wr(8'h0c, 8'h5a, 8'h00, 1);
    `CHK("ctl4", 8'h5a, bank.control_four)
    rchk("r0c", 8'h0c, 8'h5a);
    i2c_host_model_i.write(7'h6b, 8'h00, 8'h01, 8'h00, 1);
    `CHK("nack", 1'b0, i2c_host_model_i.acked)
    `CHK("limit", 5'h17, limit)
    $display("test refusals done");
    sel_pin = 1'b1;
    settle();
    pulse(det_pin);
    `CHK("limit", 5'h04, limit)
    sel_pin = 1'b0;
    settle();
    pulse(det_pin);
    `CHK("limit", 5'h17, limit)
    wr(8'h00, 8'h0a, 8'h00, 1);
    `CHK("limit", 5'h0a, limit)
    pulse(reg_rst);
    rchk("r00", 8'h00, 8'h17);
    `CHK("bank", 64'h1a91000000000000, bank)
    $display("test detect done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
